// file: src/adq_pkg.sv
// Shared constants and types of the converter sequencer
package adq_pkg;

	// ----------------------------------------------------------------
	// Register byte offsets
	// ----------------------------------------------------------------
	localparam logic [7:0] ADQ_OFS_CTRL0    = 8'h00;
	localparam logic [7:0] ADQ_OFS_CTRL1    = 8'h04;
	localparam logic [7:0] ADQ_OFS_CTRL2    = 8'h08;
	localparam logic [7:0] ADQ_OFS_RES_HIGH = 8'h0C;
	localparam logic [7:0] ADQ_OFS_RES_LOW  = 8'h10;
	localparam logic [7:0] ADQ_OFS_STATUS   = 8'h14;

	// ----------------------------------------------------------------
	// Field positions
	// ----------------------------------------------------------------
	localparam int ADQ_C0_ENABLE   = 0;
	localparam int ADQ_C0_GO       = 1;
	localparam int ADQ_C0_CHAN_LSB = 2;
	localparam int ADQ_C0_CHAN_MSB = 5;
	localparam int ADQ_C2_CLK_LSB  = 0;
	localparam int ADQ_C2_CLK_MSB  = 2;
	localparam int ADQ_C2_ACQ_LSB  = 3;
	localparam int ADQ_C2_ACQ_MSB  = 5;
	localparam int ADQ_C2_JUSTIFY  = 7;
	localparam int ADQ_ST_DONE     = 0;

	// Writable bit masks; the rest read as zero
	localparam logic [7:0] ADQ_C0_MASK = 8'h3F;
	localparam logic [7:0] ADQ_C2_MASK = 8'hBF;

	// ----------------------------------------------------------------
	// Reset values
	// ----------------------------------------------------------------
	localparam logic [7:0] ADQ_C0_RESET = 8'h00;
	localparam logic [7:0] ADQ_C1_RESET = 8'h00;
	localparam logic [7:0] ADQ_C2_RESET = 8'h00;

	// ----------------------------------------------------------------
	// Timing
	// ----------------------------------------------------------------
	localparam int ADQ_RES_BITS   = 12;
	localparam int ADQ_CONV_TADS  = 13;
	localparam int ADQ_LAST_CHAN  = 12;
	localparam int ADQ_CLK_NS     = 10;
	localparam int ADQ_TCY_OSC    = 4;
	localparam int ADQ_RC_TAD_NS  = 2500;
	localparam int ADQ_RC_CYCLES  = ADQ_RC_TAD_NS / ADQ_CLK_NS;

	// Sequencer states, Gray along idle, acquire, convert
	typedef enum logic [1:0] {
		ADQ_IDLE    = 2'b00,
		ADQ_ACQUIRE = 2'b01,
		ADQ_CONVERT = 2'b11
	} adq_state_t;

endpackage

// file: src/adq_tad_gen.sv
// Conversion clock period generator: oscillator divider or RC source
`timescale 1ns/1ps
module adq_tad_gen #(
	parameter int RC_CYCLES = adq_pkg::ADQ_RC_CYCLES
) (
	// Clock and reset
	input  wire logic       pclk,
	input  wire logic       presetn,
	// Control
	input  wire logic       run,
	input  wire logic [2:0] clk_sel,
	// Period tick
	output logic            tad_tick
);
	import adq_pkg::*;

	logic [15:0] cnt_reg;
	logic [15:0] limit;
	logic [2:0]  tcy_reg;
	logic        use_rc;

	assign use_rc = (clk_sel[1:0] == 2'b11);

	// Oscillator divide by 2,8,32 for codes 0xx and 4,16,64 with bit 2 set
	always_comb begin
		limit = 16'h0000;
		if (use_rc) begin
			limit = 16'(RC_CYCLES - 1);
		end else begin
			limit = 16'((2 << (2 * clk_sel[1:0] + {1'b0, clk_sel[2]})) - 1);
		end
	end

	// One instruction cycle of delay before the RC clock starts
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			tcy_reg <= 3'h0;
		end else if (!run) begin
			tcy_reg <= 3'h0;
		end else if (use_rc && tcy_reg != 3'(ADQ_TCY_OSC)) begin
			tcy_reg <= tcy_reg + 3'h1;
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			cnt_reg  <= 16'h0000;
			tad_tick <= 1'b0;
		end else if (!run || (use_rc && tcy_reg != 3'(ADQ_TCY_OSC))) begin
			cnt_reg  <= 16'h0000;
			tad_tick <= 1'b0;
		end else if (cnt_reg >= limit) begin
			cnt_reg  <= 16'h0000;
			tad_tick <= 1'b1;
		end else begin
			cnt_reg  <= cnt_reg + 16'h0001;
			tad_tick <= 1'b0;
		end
	end

endmodule

// file: src/adq_sar.sv
// Successive-approximation engine, thirteen conversion clock periods
`timescale 1ns/1ps
module adq_sar #(
	parameter int RES_BITS = adq_pkg::ADQ_RES_BITS
) (
	// Clock and reset
	input  wire logic                pclk,
	input  wire logic                presetn,
	// Control
	input  wire logic                start,
	input  wire logic                abort,
	input  wire logic                tad_tick,
	input  wire logic                cmp_high,
	// Results
	output logic [RES_BITS-1:0]      trial_code,
	output logic [RES_BITS-1:0]      result,
	output logic                     done
);
	import adq_pkg::*;

	logic [3:0] step_reg;
	logic       busy_reg;
	logic [3:0] bit_idx;

	assign bit_idx = 4'(RES_BITS) - step_reg;

	// Period 0 sets the top trial bit, each later period resolves one bit
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			step_reg   <= 4'h0;
			busy_reg   <= 1'b0;
			trial_code <= '0;
			result     <= '0;
			done       <= 1'b0;
		end else begin
			done <= 1'b0;
			if (abort) begin
				busy_reg <= 1'b0;
			end else if (start) begin
				busy_reg   <= 1'b1;
				step_reg   <= 4'h0;
				trial_code <= '0;
			end else if (busy_reg && tad_tick) begin
				if (step_reg != 4'h0 && !cmp_high) begin
					trial_code[bit_idx] <= 1'b0;
				end
				if (step_reg == 4'(ADQ_CONV_TADS - 1)) begin
					busy_reg <= 1'b0;
					done     <= 1'b1;
					result   <= cmp_high ? trial_code
						: (trial_code & ~(RES_BITS'(1)));
				end else begin
					trial_code[bit_idx - 4'h1] <= 1'b1;
					step_reg <= step_reg + 4'h1;
				end
			end
		end
	end

endmodule

// file: src/adq_top.sv
// APB register file and sequencer of the 12-bit converter
//
// Chosen here: the register addresses and register access over APB.
`timescale 1ns/1ps

// Notes on behaviour
// - Sampled input becomes a 12-bit result
// - Channel field picks inputs 0 to 12
// - Unimplemented channel codes still convert fully
// - Status bit high while conversion runs
// - Enable bit switches converter on and off
// - Unimplemented control bits read as zero
// - Justify bit: 1 right, 0 left
// - Acquisition code gives 0 to 20 periods
// - Clock code picks divider or RC source
// - RC source waits one instruction cycle
// - Nonzero acquisition samples then converts automatically
// - Code zero converts at once
// - Acquisition field resets to zero
// - Completion clears status, sets flag, resamples
// - Status stays set through both phases
// - Conversion lasts thirteen clock periods
// - Capacitor disconnects when conversion starts
// - Compare trigger starts only when enabled
module adq_top #(
	parameter int RC_CYCLES = adq_pkg::ADQ_RC_CYCLES
) (
	// APB
	input  wire logic        pclk,
	input  wire logic        presetn,
	input  wire logic        psel,
	input  wire logic        penable,
	input  wire logic        pwrite,
	input  wire logic [7:0]  paddr,
	input  wire logic [31:0] pwdata,
	output logic      [31:0] prdata,
	output logic             pready,
	output logic             pslverr,
	// Compare unit trigger
	input  wire logic [3:0]  capture_compare_unit_two_mode,
	input  wire logic        capture_compare_unit_two_event,
	// Analog front end
	input  wire logic        comparator_high,
	output logic      [3:0]  channel_select,
	output logic             sampling_capacitor_connect,
	output logic      [11:0] dac_code,
	output logic             conversion_done_flag,
	output logic      [7:0]  port_config
);
	import adq_pkg::*;

	// ----------------------------------------------------------------
	// Declarations
	// ----------------------------------------------------------------
	logic [7:0]  converter_control_0_reg;
	logic [7:0]  converter_control_1_reg;
	logic [7:0]  converter_control_2_reg;
	logic [7:0]  result_high_byte_reg;
	logic [7:0]  result_low_byte_reg;
	logic        done_flag_reg;
	adq_state_t  state_reg;
	adq_state_t  state_next;
	logic [4:0]  acq_cnt_reg;
	logic [4:0]  acq_periods;
	logic        cmp_meta_reg;
	logic        cmp_sync_reg;
	logic        wr_en;
	logic        rd_en;
	logic        mapped;
	logic [7:0]  rd_byte;
	logic        sw_start;
	logic        hw_start;
	logic        start;
	logic        conv_start;
	logic        tad_tick;
	logic        sar_done;
	logic [11:0] sar_result;
	logic [11:0] sar_trial;
	logic        converter_enable;
	logic        result_justify;
	logic [2:0]  acquisition_time_select;
	logic [2:0]  conversion_clock_select;

	assign converter_enable = converter_control_0_reg[ADQ_C0_ENABLE];
	assign result_justify   = converter_control_2_reg[ADQ_C2_JUSTIFY];
	assign acquisition_time_select =
		converter_control_2_reg[ADQ_C2_ACQ_MSB:ADQ_C2_ACQ_LSB];
	assign conversion_clock_select =
		converter_control_2_reg[ADQ_C2_CLK_MSB:ADQ_C2_CLK_LSB];

	// ----------------------------------------------------------------
	// APB access decode
	// ----------------------------------------------------------------
	assign wr_en = psel && penable && pready && pwrite;
	assign rd_en = psel && !penable;

	always_comb begin
		mapped  = 1'b1;
		rd_byte = 8'h00;
		if (paddr == ADQ_OFS_CTRL0) begin
			rd_byte = converter_control_0_reg & ADQ_C0_MASK;
		end else if (paddr == ADQ_OFS_CTRL1) begin
			rd_byte = converter_control_1_reg;
		end else if (paddr == ADQ_OFS_CTRL2) begin
			rd_byte = converter_control_2_reg & ADQ_C2_MASK;
		end else if (paddr == ADQ_OFS_RES_HIGH) begin
			rd_byte = result_high_byte_reg;
		end else if (paddr == ADQ_OFS_RES_LOW) begin
			rd_byte = result_low_byte_reg;
		end else if (paddr == ADQ_OFS_STATUS) begin
			rd_byte = {7'h00, done_flag_reg};
		end else begin
			mapped = 1'b0;
		end
	end

	// Zero wait states: ready rises for the access phase
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			pready  <= 1'b0;
			pslverr <= 1'b0;
		end else begin
			pready  <= psel && !penable;
			pslverr <= psel && !penable && !mapped;
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			prdata <= 32'h00000000;
		end else if (rd_en) begin
			prdata <= pwrite ? 32'h00000000 : {24'h000000, rd_byte};
		end
	end

	// ----------------------------------------------------------------
	// Start sources
	// ----------------------------------------------------------------
	assign sw_start = wr_en && paddr == ADQ_OFS_CTRL0
		&& pwdata[ADQ_C0_GO] && pwdata[ADQ_C0_ENABLE]
		&& state_reg == ADQ_IDLE;
	assign hw_start = capture_compare_unit_two_event && capture_compare_unit_two_mode == 4'hB
		&& converter_enable && state_reg == ADQ_IDLE;
	assign start      = sw_start || hw_start;
	assign conv_start = (start && acquisition_time_select == 3'h0)
		|| (state_reg == ADQ_ACQUIRE && tad_tick
		&& acq_cnt_reg == 5'h01);

	// ----------------------------------------------------------------
	// Control register 0
	// ----------------------------------------------------------------
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			converter_control_0_reg <= ADQ_C0_RESET;
		end else begin
			if (wr_en && paddr == ADQ_OFS_CTRL0) begin
				converter_control_0_reg[ADQ_C0_CHAN_MSB:ADQ_C0_CHAN_LSB] <=
					pwdata[ADQ_C0_CHAN_MSB:ADQ_C0_CHAN_LSB];
				converter_control_0_reg[ADQ_C0_ENABLE] <=
					pwdata[ADQ_C0_ENABLE];
			end
			if (start) begin
				converter_control_0_reg[ADQ_C0_GO] <= 1'b1;
			end else if (sar_done || state_reg == ADQ_IDLE) begin
				converter_control_0_reg[ADQ_C0_GO] <= 1'b0;
			end
		end
	end

	// ----------------------------------------------------------------
	// Control registers 1 and 2
	// ----------------------------------------------------------------
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			converter_control_1_reg <= ADQ_C1_RESET;
		end else if (wr_en && paddr == ADQ_OFS_CTRL1) begin
			converter_control_1_reg <= pwdata[7:0];
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			converter_control_2_reg <= ADQ_C2_RESET;
		end else if (wr_en && paddr == ADQ_OFS_CTRL2) begin
			converter_control_2_reg <= pwdata[7:0] & ADQ_C2_MASK;
		end
	end

	// ----------------------------------------------------------------
	// Acquisition periods per code
	// ----------------------------------------------------------------
	always_comb begin
		case (acquisition_time_select)
			3'h7: acq_periods = 5'd20;
			3'h6: acq_periods = 5'd16;
			3'h5: acq_periods = 5'd12;
			3'h4: acq_periods = 5'd8;
			3'h3: acq_periods = 5'd6;
			3'h2: acq_periods = 5'd4;
			3'h1: acq_periods = 5'd2;
			default: acq_periods = 5'd0;
		endcase
	end

	// ----------------------------------------------------------------
	// Sequencer
	// ----------------------------------------------------------------
	always_comb begin
		state_next = state_reg;
		case (state_reg)
			ADQ_IDLE: begin
				if (conv_start) begin
					state_next = ADQ_CONVERT;
				end else if (start) begin
					state_next = ADQ_ACQUIRE;
				end
			end
			ADQ_ACQUIRE: begin
				if (conv_start) begin
					state_next = ADQ_CONVERT;
				end
			end
			ADQ_CONVERT: begin
				if (sar_done) begin
					state_next = ADQ_IDLE;
				end
			end
			default: state_next = ADQ_IDLE;
		endcase
		if (!converter_enable) begin
			state_next = ADQ_IDLE;
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			state_reg <= ADQ_IDLE;
		end else begin
			state_reg <= state_next;
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			acq_cnt_reg <= 5'h00;
		end else if (start) begin
			acq_cnt_reg <= acq_periods;
		end else if (state_reg == ADQ_ACQUIRE && tad_tick) begin
			acq_cnt_reg <= acq_cnt_reg - 5'h01;
		end
	end

	// ----------------------------------------------------------------
	// Comparator synchroniser
	// ----------------------------------------------------------------
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			cmp_meta_reg <= 1'b0;
			cmp_sync_reg <= 1'b0;
		end else begin
			cmp_meta_reg <= comparator_high;
			cmp_sync_reg <= cmp_meta_reg;
		end
	end

	// ----------------------------------------------------------------
	// Conversion clock and approximation engine
	// ----------------------------------------------------------------
	adq_tad_gen #(
		.RC_CYCLES (RC_CYCLES)
	) u_tad (
		.pclk     (pclk),
		.presetn  (presetn),
		.run      (state_reg != ADQ_IDLE),
		.clk_sel  (conversion_clock_select),
		.tad_tick (tad_tick)
	);

	// Any channel code converts the same way, valid or not
	adq_sar #(
		.RES_BITS (ADQ_RES_BITS)
	) u_sar (
		.pclk       (pclk),
		.presetn    (presetn),
		.start      (conv_start),
		.abort      (!converter_enable),
		.tad_tick   (tad_tick),
		.cmp_high   (cmp_sync_reg),
		.trial_code (sar_trial),
		.result     (sar_result),
		.done       (sar_done)
	);

	// ----------------------------------------------------------------
	// Result bytes
	// ----------------------------------------------------------------
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			result_high_byte_reg <= 8'h00;
			result_low_byte_reg  <= 8'h00;
		end else if (sar_done) begin
			if (result_justify) begin
				result_high_byte_reg <= {4'h0, sar_result[11:8]};
				result_low_byte_reg  <= sar_result[7:0];
			end else begin
				result_high_byte_reg <= sar_result[11:4];
				result_low_byte_reg  <= {sar_result[3:0], 4'h0};
			end
		end
	end

	// ----------------------------------------------------------------
	// Completion flag, write one to clear, set wins
	// ----------------------------------------------------------------
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			done_flag_reg <= 1'b0;
		end else if (sar_done) begin
			done_flag_reg <= 1'b1;
		end else if (wr_en && paddr == ADQ_OFS_STATUS
			&& pwdata[ADQ_ST_DONE]) begin
			done_flag_reg <= 1'b0;
		end
	end

	// ----------------------------------------------------------------
	// Front end outputs
	// ----------------------------------------------------------------
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			channel_select             <= 4'h0;
			sampling_capacitor_connect <= 1'b0;
			dac_code                   <= 12'h000;
			conversion_done_flag       <= 1'b0;
			port_config                <= ADQ_C1_RESET;
		end else begin
			channel_select <=
				converter_control_0_reg[ADQ_C0_CHAN_MSB:ADQ_C0_CHAN_LSB];
			sampling_capacitor_connect <= converter_enable
				&& state_next != ADQ_CONVERT;
			dac_code             <= sar_trial;
			conversion_done_flag <= done_flag_reg;
			port_config          <= converter_control_1_reg;
		end
	end

endmodule

// file: bench/adq_assertions.sv
// Port assertions of the converter sequencer
`timescale 1ns/1ps
module adq_assertions #(
	parameter int RC_CYCLES = 4
) (
	// APB
	input wire logic        pclk,
	input wire logic        presetn,
	input wire logic        psel,
	input wire logic        penable,
	input wire logic        pwrite,
	input wire logic [7:0]  paddr,
	input wire logic [31:0] pwdata,
	input wire logic [31:0] prdata,
	input wire logic        pready,
	input wire logic        pslverr,
	// Trigger and front end
	input wire logic [3:0]  capture_compare_unit_two_mode,
	input wire logic        capture_compare_unit_two_event,
	input wire logic        comparator_high,
	input wire logic [3:0]  channel_select,
	input wire logic        sampling_capacitor_connect,
	input wire logic [11:0] dac_code,
	input wire logic        conversion_done_flag,
	input wire logic [7:0]  port_config
);
	import adq_pkg::*;
	logic acc, rd, wr_st, mapped;
	assign acc = psel && penable;
	assign rd = acc && !pwrite;
	assign wr_st = acc && pwrite && paddr == ADQ_OFS_STATUS;
	assign mapped = paddr <= ADQ_OFS_STATUS && paddr[1:0] == 2'b00;
	default clocking cb @(posedge pclk); endclocking
	default disable iff (!presetn);
	chk_ready_access: assert property (psel && !penable |=> pready)
		else $error("no ready in access phase");
	chk_err_unmapped: assert property (acc && !mapped |-> pslverr
		&& prdata == 32'h0000_0000) else $error("unmapped not refused");
	chk_err_mapped: assert property (acc && mapped |-> !pslverr)
		else $error("mapped access refused");
	chk_upper_zero: assert property (rd |-> prdata[31:8] == 24'h00_0000)
		else $error("upper read bits set");
	chk_ctrl0_unused: assert property (
		rd && paddr == ADQ_OFS_CTRL0 |-> prdata[7:6] == 2'b00)
		else $error("control0 spare bits set");
	chk_ctrl2_unused: assert property (
		rd && paddr == ADQ_OFS_CTRL2 |-> !prdata[6])
		else $error("control2 spare bit set");
	chk_chan_mirror: assert property (
		acc && pwrite && paddr == ADQ_OFS_CTRL0
		|-> ##2 channel_select == $past(pwdata[5:2], 2))
		else $error("channel output wrong");
	chk_flag_hold: assert property (
		conversion_done_flag && !wr_st && !$past(wr_st)
		|=> conversion_done_flag) else $error("flag lost");
	chk_cap_on_done: assert property (
		$rose(conversion_done_flag) |-> ##[0:2] sampling_capacitor_connect)
		else $error("no resampling after done");
	chk_cap_off_conv: assert property (
		$rose(conversion_done_flag)
		|-> !$past(sampling_capacitor_connect, 3))
		else $error("capacitor connected while converting");
endmodule

// file: bench/adq_analog_model.sv
// Analog inputs and sampling capacitor facing the converter
`timescale 1ns/1ps
module adq_analog_model (
	// Clock
	input wire logic        pclk,
	// Front end
	input wire logic [3:0]  channel_select,
	input wire logic        sampling_capacitor_connect,
	input wire logic [11:0] dac_code,
	output logic            comparator_high
);
	logic [11:0] lvl [0:12];
	logic [11:0] hold_reg = 12'h000;
	// Capacitor follows the pin only while connected
	always_ff @(posedge pclk) begin
		if (sampling_capacitor_connect) begin
			if (channel_select <= 4'hC)
				hold_reg <= lvl[channel_select];
			else
				hold_reg <= ~hold_reg;
		end
	end
	// Input sits half a step above the held code
	assign comparator_high = dac_code <= hold_reg;
endmodule

// file: bench/adq_top_tb.sv
// Self-checking bench of the converter sequencer
`timescale 1ns/1ps
module adq_top_tb;
	import adq_pkg::*;
	localparam int RC = 6;
	logic        pclk, presetn, psel, penable, pwrite, pready, pslverr;
	logic [7:0]  paddr, port_config;
	logic [31:0] pwdata, prdata, q;
	logic [3:0]  capture_compare_unit_two_mode, channel_select;
	logic        capture_compare_unit_two_event, comparator_high, e;
	logic        sampling_capacitor_connect, conversion_done_flag;
	logic [11:0] dac_code;
	int          err_count, n_tests;
	int          cyc = 0;
	int          divs [8] = '{2, 8, 32, RC, 4, 16, 64, RC};
	int          acqs [8] = '{0, 2, 4, 6, 8, 12, 16, 20};

	adq_top #(.RC_CYCLES(RC)) dut (.pclk(pclk), .presetn(presetn),
		.psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
		.pwdata(pwdata), .prdata(prdata), .pready(pready),
		.pslverr(pslverr), .capture_compare_unit_two_mode(capture_compare_unit_two_mode), .capture_compare_unit_two_event(capture_compare_unit_two_event),
		.comparator_high(comparator_high), .channel_select(channel_select),
		.sampling_capacitor_connect(sampling_capacitor_connect),
		.dac_code(dac_code), .conversion_done_flag(conversion_done_flag),
		.port_config(port_config));
	adq_analog_model model (.pclk(pclk), .channel_select(channel_select),
		.sampling_capacitor_connect(sampling_capacitor_connect),
		.dac_code(dac_code), .comparator_high(comparator_high));

	always #5 pclk = ~pclk;
	always @(posedge pclk) cyc <= cyc + 1;

	// ----------------------------------------------------------------
	// Shared tasks
	// ----------------------------------------------------------------
	task automatic check(input string nm, input logic [31:0] seen, exp);
		n_tests++;
		if (seen !== exp) begin
			err_count++;
			$display("CHECK FAILED %s expected %h seen %h", nm, exp, seen);
		end
	endtask
	task automatic apb(input logic w, input logic [7:0] a,
		input logic [31:0] d);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		do begin
			@(posedge pclk);
		end while (pready !== 1'b1);
		q = prdata;
		e = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		@(posedge pclk);
	endtask
	task automatic rd(input logic [7:0] a, input string nm,
		input logic [31:0] exp);
		apb(1'b0, a, 32'h0);
		check(nm, q, exp);
	endtask
	task automatic wait_flag();
		int n;
		n = 0;
		while (conversion_done_flag !== 1'b1 && n < 4000) begin
			@(posedge pclk);
			n++;
		end
		check("done flag", conversion_done_flag, 1'b1);
	endtask
	task automatic pulse(input logic [3:0] m);
		capture_compare_unit_two_mode <= m;
		capture_compare_unit_two_event <= 1'b1;
		@(posedge pclk);
		capture_compare_unit_two_event <= 1'b0;
		@(posedge pclk);
	endtask

	// ----------------------------------------------------------------
	// Scenarios
	// ----------------------------------------------------------------
	task automatic t_regs();
		rd(ADQ_OFS_CTRL0, "ctrl0 reset", 32'h00);
		rd(ADQ_OFS_CTRL2, "ctrl2 reset", 32'h00);
		apb(1'b1, ADQ_OFS_CTRL0, 32'hFFFF_FFFC);
		rd(ADQ_OFS_CTRL0, "ctrl0 bits", 32'h3C);
		apb(1'b1, ADQ_OFS_CTRL2, 32'hFF);
		rd(ADQ_OFS_CTRL2, "ctrl2 bits", 32'hBF);
		apb(1'b1, ADQ_OFS_CTRL1, 32'h5A);
		@(posedge pclk);
		check("port config", port_config, 8'h5A);
		apb(1'b1, 8'h18, 32'hFF);
		check("unmapped err", e, 1'b1);
		rd(8'h18, "unmapped data", 32'h0);
		apb(1'b1, ADQ_OFS_CTRL0, 32'h0);
		apb(1'b1, ADQ_OFS_CTRL2, 32'h0);
		$display("register test done");
	endtask
	task automatic t_convert(input logic [3:0] ch, input logic [2:0] acq,
		input logic [2:0] clk, input logic j);
		int d, lo, tad;
		logic [11:0] v;
		logic [15:0] p;
		v = 12'h5A3 + 12'(ch) * 12'h111;
		p = j ? {4'h0, v} : {v, 4'h0};
		tad = divs[clk];
		lo = (acqs[acq] + 13) * tad;
		if (ch <= 4'hC) model.lvl[ch] <= v;
		apb(1'b1, ADQ_OFS_CTRL2, {24'h0, j, 1'b0, acq, clk});
		apb(1'b1, ADQ_OFS_CTRL0, {26'h0, ch, 2'b01});
		repeat (30) @(posedge pclk);
		apb(1'b1, ADQ_OFS_CTRL0, {26'h0, ch, 2'b11});
		d = cyc;
		apb(1'b0, ADQ_OFS_CTRL0, 32'h0);
		check("busy", q[1], 1'b1);
		if (acq == 3'b000 && ch <= 4'hC) model.lvl[ch] <= ~v;
		check("channel", channel_select, ch);
		wait_flag();
		d = cyc - d;
		check("time low", d >= lo - 2, 1'b1);
		check("time high", d <= lo + tad + 12, 1'b1);
		rd(ADQ_OFS_CTRL0, "go clear", {26'h0, ch, 2'b01});
		rd(ADQ_OFS_STATUS, "status set", 32'h1);
		if (tad >= 6 && ch <= 4'hC) begin
			rd(ADQ_OFS_RES_HIGH, "res high", p[15:8]);
			rd(ADQ_OFS_RES_LOW, "res low", p[7:0]);
		end
		apb(1'b1, ADQ_OFS_STATUS, 32'h1);
		rd(ADQ_OFS_STATUS, "status clear", 32'h0);
		$display("conversion test done");
	endtask
	task automatic t_abort();
		apb(1'b1, ADQ_OFS_CTRL2, 32'h3E);
		apb(1'b1, ADQ_OFS_CTRL0, 32'h05);
		apb(1'b1, ADQ_OFS_CTRL0, 32'h07);
		rd(ADQ_OFS_CTRL0, "abort busy", 32'h07);
		apb(1'b1, ADQ_OFS_CTRL0, 32'h04);
		repeat (2200) @(posedge pclk);
		rd(ADQ_OFS_CTRL0, "abort idle", 32'h04);
		check("abort flag", conversion_done_flag, 1'b0);
		$display("abort test done");
	endtask
	task automatic t_trigger();
		model.lvl[2] <= 12'h3C7;
		apb(1'b1, ADQ_OFS_CTRL2, 32'h01);
		apb(1'b1, ADQ_OFS_CTRL0, 32'h09);
		repeat (30) @(posedge pclk);
		pulse(4'hA);
		rd(ADQ_OFS_CTRL0, "wrong mode", 32'h09);
		apb(1'b1, ADQ_OFS_CTRL0, 32'h08);
		pulse(4'hB);
		rd(ADQ_OFS_CTRL0, "disabled", 32'h08);
		apb(1'b1, ADQ_OFS_CTRL0, 32'h09);
		repeat (30) @(posedge pclk);
		pulse(4'hB);
		rd(ADQ_OFS_CTRL0, "triggered", 32'h0B);
		wait_flag();
		rd(ADQ_OFS_RES_HIGH, "trig high", 32'h3C);
		rd(ADQ_OFS_RES_LOW, "trig low", 32'h70);
		$display("trigger test done");
	endtask
	task automatic conclude();
		$display("checks %0d mismatches %0d", n_tests, err_count);
		if (err_count == 0 && n_tests > 0)
			$display("[ PASS ]");
		else
			$display("[ FAIL ]");
		$finish;
	endtask

	// ----------------------------------------------------------------
	// Main sequence and watchdog
	// ----------------------------------------------------------------
	initial begin
		pclk = 1'b0;
		presetn = 1'b0;
		{psel, penable, pwrite, capture_compare_unit_two_event} = 4'h0;
		paddr = 8'h00;
		pwdata = 32'h0;
		capture_compare_unit_two_mode = 4'h0;
		err_count = 0;
		n_tests = 0;
		for (int i = 0; i < 13; i++) model.lvl[i] = 12'h000;
		repeat (4) @(posedge pclk);
		presetn <= 1'b1;
		@(posedge pclk);
		t_regs();
		for (int c = 0; c < 8; c++) t_convert(4'd3, 3'd0, 3'(c), 1'b1);
		for (int a = 1; a < 8; a++) t_convert(4'(a + 5), 3'(a), 3'd1, a[0]);
		t_convert(4'd13, 3'd2, 3'd1, 1'b0);
		t_abort();
		t_trigger();
		conclude();
	end
	initial begin
		#200_000;
		err_count++;
		conclude();
	end
endmodule

bind adq_top adq_assertions #(.RC_CYCLES(RC_CYCLES)) chk_i (
	.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
	.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
	.pready(pready), .pslverr(pslverr), .capture_compare_unit_two_mode(capture_compare_unit_two_mode),
	.capture_compare_unit_two_event(capture_compare_unit_two_event), .comparator_high(comparator_high),
	.channel_select(channel_select), .dac_code(dac_code),
	.sampling_capacitor_connect(sampling_capacitor_connect),
	.conversion_done_flag(conversion_done_flag),
	.port_config(port_config));
